/* File: core/clockgen_defines.vh */
`ifndef CLOCKGEN_DEFINES_VH
`define CLOCKGEN_DEFINES_VH

// Register indices
`define IDX_OUTPUT_ENABLE_CTRL    8'h00
`define IDX_SPREAD_AMPLITUDE_CTRL 8'h01
`define IDX_PAIR_EDGE_RATE_CTRL   8'h02
`define IDX_CRYSTAL_COPY_CTRL     8'h03
`define IDX_RESERVED_ALL_ONES     8'h04
`define IDX_REVISION_VENDOR_IDENT 8'h05
`define IDX_DEVICE_CATEGORY_IDENT 8'h06
`define IDX_BLOCK_READ_LENGTH     8'h07

// Reset values of writable fields
`define RST_PAIR_OE        4'hF
`define RST_SPREAD_SW_SEL  1'b0
`define RST_SPREAD_AMOUNT  2'h0
`define RST_AMPLITUDE      2'h2
`define RST_PAIR_EDGE      4'hF
`define RST_REF_EDGE       2'h1
`define RST_REF_WAKE       1'b0
`define RST_REF_OE         1'b1
`define RST_READ_LENGTH    5'h08

// Fixed read values
`define RESERVED_BYTE      8'hFF
`define RSVD_HI_NIBBLE     4'hF
`define RSVD_BIT_ONE       1'b1
`define RSVD_BYTE7_HI      3'h0

// Spread strap encodings
`define STRAP_LOW          2'h0
`define STRAP_MID          2'h1
`define STRAP_HIGH         2'h3

// Bus address, all seven bits with bit 1 clear; the strap supplies bit 1 of the seven
`define BUS_ADDR_BASE      7'h68
`define BUS_ADDR_STRAP_BIT 1

`endif

/* File: core/pin_sync.v */
`timescale 1ns/1ps
// Three-stage synchroniser; the output moves only when stages two and three agree
module pin_sync #(
    parameter RESET_VALUE = 1'b1
) (
    input  wire clk_i,
    input  wire reset_i,
    input  wire pin_i,
    output reg  level_o
);
    reg meta;
    reg stage2;
    reg stage3;

    // Metastability chain; meta feeds stage2 only
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            meta    <= RESET_VALUE;
            stage2  <= RESET_VALUE;
            stage3  <= RESET_VALUE;
            level_o <= RESET_VALUE;
        end else begin
            meta   <= pin_i;
            stage2 <= meta;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                level_o <= stage3;
            end
        end
    end
endmodule

/* File: core/smbus_target.v */
`timescale 1ns/1ps
`include "clockgen_defines.vh"
// SMBus block-protocol target: address, index, count, data bytes
module smbus_target (
    input  wire       clk_i,
    input  wire       reset_i,
    input  wire       scl_i,
    input  wire       sda_i,
    input  wire [6:0] bus_address_i,
    input  wire [4:0] read_length_i,
    input  wire [7:0] rd_data_i,
    output reg  [7:0] index_o,
    output reg  [7:0] wr_data_o,
    output reg        wr_strobe_o,
    output reg        sda_oe_o
);
    localparam [5:0] ST_IDLE  = 6'h01;
    localparam [5:0] ST_RECV  = 6'h02;
    localparam [5:0] ST_ACK   = 6'h04;
    localparam [5:0] ST_SEND  = 6'h08;
    localparam [5:0] ST_MACK  = 6'h10;
    localparam [5:0] ST_WAIT  = 6'h20;

    localparam [1:0] PH_ADDR  = 2'h0;
    localparam [1:0] PH_INDEX = 2'h1;
    localparam [1:0] PH_COUNT = 2'h2;
    localparam [1:0] PH_DATA  = 2'h3;

    reg [5:0] state;
    reg [1:0] phase;
    reg [2:0] bit_cnt;
    reg [7:0] shift;
    reg       scl_d;
    reg       sda_d;
    reg       reading;
    reg       host_acked;

    wire scl_rise = scl_i & ~scl_d;
    wire scl_fall = ~scl_i & scl_d;
    wire start_c  = scl_i & scl_d & sda_d & ~sda_i;
    wire stop_c   = scl_i & scl_d & ~sda_d & sda_i;

    // Byte-level engine; start and stop take priority over bit traffic
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state       <= ST_IDLE;
            phase       <= PH_ADDR;
            bit_cnt     <= 3'h0;
            shift       <= 8'h00;
            scl_d       <= 1'b1;
            sda_d       <= 1'b1;
            reading     <= 1'b0;
            host_acked  <= 1'b0;
            index_o     <= 8'h00;
            wr_data_o   <= 8'h00;
            wr_strobe_o <= 1'b0;
            sda_oe_o    <= 1'b0;
        end else begin
            scl_d       <= scl_i;
            sda_d       <= sda_i;
            wr_strobe_o <= 1'b0;
            if (start_c) begin
                state    <= ST_RECV;
                phase    <= PH_ADDR;
                bit_cnt  <= 3'h0;
                sda_oe_o <= 1'b0;
                host_acked <= 1'b0;
            end else if (stop_c) begin
                state    <= ST_IDLE;
                sda_oe_o <= 1'b0;
            end else begin
                case (state)
                    ST_RECV: begin
                        if (scl_rise) begin
                            shift   <= {shift[6:0], sda_i};
                            bit_cnt <= bit_cnt + 3'h1;
                            if (bit_cnt == 3'h7) begin
                                state <= ST_ACK;
                            end
                        end
                    end
                    ST_ACK: begin
                        // Drive ack on the falling edge after the eighth bit
                        if (scl_fall && !sda_oe_o) begin
                            case (phase)
                                PH_ADDR: begin
                                    if (shift[7:1] == bus_address_i) begin
                                        sda_oe_o   <= 1'b1;
                                        reading    <= shift[0];
                                    end else begin
                                        state <= ST_WAIT;
                                    end
                                end
                                PH_INDEX: begin
                                    index_o  <= shift;
                                    sda_oe_o <= 1'b1;
                                end
                                PH_COUNT: begin
                                    // Count is acknowledged but not enforced
                                    sda_oe_o <= 1'b1;
                                end
                                default: begin
                                    wr_data_o   <= shift;
                                    wr_strobe_o <= 1'b1;
                                    sda_oe_o    <= 1'b1;
                                end
                            endcase
                        end else if (scl_fall && sda_oe_o) begin
                            // Ack clocked out; release and pick next phase
                            sda_oe_o <= 1'b0;
                            bit_cnt  <= 3'h0;
                            if (phase == PH_ADDR && reading) begin
                                state <= ST_SEND;
                                shift <= {3'h0, read_length_i};
                            end else begin
                                state <= ST_RECV;
                                if (phase == PH_DATA) begin
                                    index_o <= index_o + 8'h01;
                                end else if (phase == PH_ADDR) begin
                                    phase <= PH_INDEX;
                                end else if (phase == PH_INDEX) begin
                                    phase <= PH_COUNT;
                                end else begin
                                    phase <= PH_DATA;
                                end
                            end
                        end
                    end
                    ST_SEND: begin
                        // Open-drain: enable only to pull a zero low
                        sda_oe_o <= ~shift[7];
                        if (scl_fall) begin
                            shift   <= {shift[6:0], 1'b1};
                            bit_cnt <= bit_cnt + 3'h1;
                            sda_oe_o <= ~shift[6];
                            if (bit_cnt == 3'h7) begin
                                state    <= ST_MACK;
                                sda_oe_o <= 1'b0;
                            end
                        end
                    end
                    ST_MACK: begin
                        // Host ack continues, nack ends the read
                        if (scl_rise) begin
                            if (sda_i) begin
                                state <= ST_WAIT;
                            end else begin
                                // Load this index, then step so the next byte is ready
                                host_acked <= 1'b1;
                                bit_cnt    <= 3'h0;
                                shift      <= rd_data_i;
                                index_o    <= index_o + 8'h01;
                            end
                        end else if (scl_fall && host_acked) begin
                            // Wait for SCL low so data never moves while it is high
                            host_acked <= 1'b0;
                            state      <= ST_SEND;
                        end
                    end
                    default: begin
                        sda_oe_o <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule

/* File: core/clockgen_smbus_control_regs.v */
`timescale 1ns/1ps
`include "clockgen_defines.vh"
module clockgen_smbus_control_regs #(
    parameter [3:0] SILICON_REVISION_CODE = 4'h3,  // Arbitrary value
    parameter [3:0] MAKER_CODE            = 4'h9,  // Arbitrary value
    parameter [1:0] DEVICE_CATEGORY_CODE  = 2'h2,  // Arbitrary value
    parameter [5:0] DEVICE_CODE           = 6'h2A  // Arbitrary value
) (
    input  wire       clk_i,
    input  wire       reset_i,
    input  wire       smbus_clk_i,
    input  wire       smbus_data_i,
    output wire       smbus_data_o,
    output wire       smbus_data_oe_o,
    input  wire       power_good_powerdown_n_i,
    input  wire       bus_address_strap_i,
    input  wire [1:0] spread_strap_i,
    output reg  [3:0] pair_output_enable_o,
    output reg  [3:0] pair_edge_rate_select_o,
    output reg  [1:0] spread_amount_o,
    output reg  [1:0] amplitude_select_o,
    output reg  [1:0] ref_edge_rate_o,
    output reg        ref_run_o,
    output reg        ref_drive_enable_o
);
    // Writable fields
    reg [3:0] pair_oe;
    reg       spread_software_select;
    reg [1:0] spread_sw_amount;
    reg [1:0] amplitude;
    reg [3:0] pair_edge;
    reg [1:0] ref_edge;
    reg       ref_wake;
    reg       ref_oe;
    reg [4:0] read_length_field;

    // Straps captured once
    reg       straps_taken;
    reg       bus_address_sel;
    reg [1:0] spread_strap_latched;

    wire       scl_sync;
    wire       sda_sync;
    wire       pwrgd_sync;
    wire [7:0] index;
    wire [7:0] wr_data;
    wire       wr_strobe;
    reg  [7:0] rd_data;
    wire [6:0] bus_address;

    // Pins from the bus and board are asynchronous to clk_i
    pin_sync #(.RESET_VALUE(1'b1)) u_sync_scl (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .pin_i   (smbus_clk_i),
        .level_o (scl_sync)
    );

    pin_sync #(.RESET_VALUE(1'b1)) u_sync_sda (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .pin_i   (smbus_data_i),
        .level_o (sda_sync)
    );

    // Power counts as not good out of reset; a high start would latch straps early
    pin_sync #(.RESET_VALUE(1'b0)) u_sync_pwrgd (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .pin_i   (power_good_powerdown_n_i),
        .level_o (pwrgd_sync)
    );

    // Straps sampled on the first power-good; later toggles leave them alone
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            straps_taken         <= 1'b0;
            bus_address_sel      <= 1'b0;
            spread_strap_latched <= `STRAP_LOW;
        end else if (pwrgd_sync && !straps_taken) begin
            straps_taken         <= 1'b1;
            bus_address_sel      <= bus_address_strap_i;
            spread_strap_latched <= (spread_strap_i == `STRAP_MID) ? `STRAP_MID :
                                    (spread_strap_i[1] ? `STRAP_HIGH : `STRAP_LOW);
        end
    end

    // Strap selects bit 1 of the address, giving two choices
    assign bus_address = `BUS_ADDR_BASE |
                         {5'h00, bus_address_sel, 1'b0};

    smbus_target u_target (
        .clk_i         (clk_i),
        .reset_i       (reset_i),
        .scl_i         (scl_sync),
        .sda_i         (sda_sync),
        .bus_address_i (bus_address),
        .read_length_i (read_length_field),
        .rd_data_i     (rd_data),
        .index_o       (index),
        .wr_data_o     (wr_data),
        .wr_strobe_o   (wr_strobe),
        .sda_oe_o      (smbus_data_oe_o)
    );

    // Open drain: only ever drives low
    assign smbus_data_o = 1'b0;

    // Register writes; only writable fields take data, others stay fixed
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pair_oe                <= `RST_PAIR_OE;
            spread_software_select <= `RST_SPREAD_SW_SEL;
            spread_sw_amount       <= `RST_SPREAD_AMOUNT;
            amplitude              <= `RST_AMPLITUDE;
            pair_edge              <= `RST_PAIR_EDGE;
            ref_edge               <= `RST_REF_EDGE;
            ref_wake               <= `RST_REF_WAKE;
            ref_oe                 <= `RST_REF_OE;
            read_length_field      <= `RST_READ_LENGTH;
        end else if (wr_strobe) begin
            if (index == `IDX_OUTPUT_ENABLE_CTRL) begin
                pair_oe <= wr_data[3:0];
            end else if (index == `IDX_SPREAD_AMPLITUDE_CTRL) begin
                spread_software_select <= wr_data[5];
                spread_sw_amount       <= wr_data[4:3];
                amplitude              <= wr_data[1:0];
            end else if (index == `IDX_PAIR_EDGE_RATE_CTRL) begin
                pair_edge <= wr_data[3:0];
            end else if (index == `IDX_CRYSTAL_COPY_CTRL) begin
                ref_edge <= wr_data[7:6];
                ref_wake <= wr_data[5];
                ref_oe   <= wr_data[4];
            end else if (index == `IDX_BLOCK_READ_LENGTH) begin
                read_length_field <= wr_data[4:0];
            end
        end
    end

    // Read mux; reserved bits return their fixed values
    always @* begin
        if (index == `IDX_OUTPUT_ENABLE_CTRL) begin
            rd_data = {`RSVD_HI_NIBBLE, pair_oe};
        end else if (index == `IDX_SPREAD_AMPLITUDE_CTRL) begin
            rd_data = {spread_strap_latched, spread_software_select,
                       spread_sw_amount, `RSVD_BIT_ONE, amplitude};
        end else if (index == `IDX_PAIR_EDGE_RATE_CTRL) begin
            rd_data = {`RSVD_HI_NIBBLE, pair_edge};
        end else if (index == `IDX_CRYSTAL_COPY_CTRL) begin
            rd_data = {ref_edge, ref_wake, ref_oe, `RSVD_HI_NIBBLE};
        end else if (index == `IDX_RESERVED_ALL_ONES) begin
            rd_data = `RESERVED_BYTE;
        end else if (index == `IDX_REVISION_VENDOR_IDENT) begin
            rd_data = {SILICON_REVISION_CODE, MAKER_CODE};
        end else if (index == `IDX_DEVICE_CATEGORY_IDENT) begin
            rd_data = {DEVICE_CATEGORY_CODE, DEVICE_CODE};
        end else if (index == `IDX_BLOCK_READ_LENGTH) begin
            rd_data = {`RSVD_BYTE7_HI, read_length_field};
        end else begin
            rd_data = `RESERVED_BYTE;
        end
    end

    // Analog controls; registered so outputs never glitch
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pair_output_enable_o    <= 4'h0;
            pair_edge_rate_select_o <= `RST_PAIR_EDGE;
            spread_amount_o         <= `RST_SPREAD_AMOUNT;
            amplitude_select_o      <= `RST_AMPLITUDE;
            ref_edge_rate_o         <= `RST_REF_EDGE;
            ref_run_o               <= 1'b0;
            ref_drive_enable_o      <= 1'b0;
        end else begin
            // Pairs held low while power is not good as well
            pair_output_enable_o    <= pwrgd_sync ? pair_oe : 4'h0;
            pair_edge_rate_select_o <= pair_edge;
            spread_amount_o         <= spread_software_select ?
                                       spread_sw_amount : spread_strap_latched;
            amplitude_select_o      <= amplitude;
            ref_edge_rate_o         <= ref_edge;
            ref_run_o               <= ref_oe & (pwrgd_sync | ref_wake);
            // Reference stays floating until the first power good
            ref_drive_enable_o      <= straps_taken;
        end
    end
endmodule

/* File: verification/clockgen_smbus_control_regs_assertions.sv */
`timescale 1ns/1ps
// Pin-level checks of the control block
module clockgen_smbus_control_regs_checker (
    input wire       clk_i,
    input wire       reset_i,
    input wire       smbus_clk_i,
    input wire       smbus_data_o,
    input wire       smbus_data_oe_o,
    input wire       power_good_powerdown_n_i,
    input wire [3:0] pair_output_enable_o,
    input wire [3:0] pair_edge_rate_select_o,
    input wire [1:0] amplitude_select_o,
    input wire [1:0] ref_edge_rate_o,
    input wire       ref_drive_enable_o
);
    reg seen_pg;
    // Sticky flag; the block cannot see power good before this does
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i)
            seen_pg <= 1'b0;
        else if (power_good_powerdown_n_i)
            seen_pg <= 1'b1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    property p_open_drain;
        smbus_data_o == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("data pin driven high");
    property p_ack_scl_low;
        $rose(smbus_data_oe_o) |-> !smbus_clk_i;
    endproperty
    a_ack_scl_low: assert property (p_ack_scl_low)
        else $error("data pulled low while clock high");
    property p_ack_hold;
        $rose(smbus_data_oe_o) |=> smbus_data_oe_o [*7];
    endproperty
    a_ack_hold: assert property (p_ack_hold)
        else $error("data pull too short");
    property p_hold_scl_high;
        smbus_clk_i [*8] |-> $stable(smbus_data_oe_o);
    endproperty
    a_hold_scl_high: assert property (p_hold_scl_high)
        else $error("data moved while clock high");
    property p_pd_pairs;
        !power_good_powerdown_n_i [*8] |-> pair_output_enable_o == 4'h0;
    endproperty
    a_pd_pairs: assert property (p_pd_pairs)
        else $error("pairs running in power down");
    property p_pre_pg;
        !seen_pg |-> pair_output_enable_o == 4'h0 && !ref_drive_enable_o;
    endproperty
    a_pre_pg: assert property (p_pre_pg)
        else $error("outputs active before power good");
    property p_reset_vals;
        $past(reset_i) |-> amplitude_select_o == 2'h2 && ref_edge_rate_o == 2'h1
            && pair_edge_rate_select_o == 4'hF;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("wrong value after reset");
    property p_amp_idle;
        smbus_clk_i [*8] |-> $stable(amplitude_select_o);
    endproperty
    a_amp_idle: assert property (p_amp_idle)
        else $error("amplitude moved without a write");
    property p_edge_idle;
        smbus_clk_i [*8] |-> $stable(pair_edge_rate_select_o) && $stable(ref_edge_rate_o);
    endproperty
    a_edge_idle: assert property (p_edge_idle)
        else $error("edge rate moved without a write");
endmodule
bind clockgen_smbus_control_regs clockgen_smbus_control_regs_checker checker_inst (
    .clk_i                   (clk_i),
    .reset_i                 (reset_i),
    .smbus_clk_i             (smbus_clk_i),
    .smbus_data_o            (smbus_data_o),
    .smbus_data_oe_o         (smbus_data_oe_o),
    .power_good_powerdown_n_i(power_good_powerdown_n_i),
    .pair_output_enable_o    (pair_output_enable_o),
    .pair_edge_rate_select_o (pair_edge_rate_select_o),
    .amplitude_select_o      (amplitude_select_o),
    .ref_edge_rate_o         (ref_edge_rate_o),
    .ref_drive_enable_o      (ref_drive_enable_o)
);

/* File: verification/smbus_host_model.sv */
`timescale 1ns/1ps
// Bus host; reports each ack bit and read byte as a result
module smbus_host_model #(
    parameter Q = 79  // Quarter bit in clocks, keeps the bus under 400 kHz
) (
    input  wire       clk_i,
    input  wire       sda_i,
    output reg        scl_o,
    output reg        sda_o,
    output reg        res_valid_o,
    output reg  [8:0] res_data_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
        res_valid_o = 1'b0;
        res_data_o = 9'h000;
    end
    task wq;
        repeat (Q) @(posedge clk_i);
    endtask
    // Data set while clock low, sampled mid-high
    task bit_io(input reg b, output reg s);
        sda_o <= b;
        wq;
        scl_o <= 1'b1;
        wq;
        s = sda_i;
        wq;
        scl_o <= 1'b0;
        wq;
    endtask
    task emit(input reg [8:0] r);
        res_data_o <= r;
        res_valid_o <= 1'b1;
        @(posedge clk_i);
        res_valid_o <= 1'b0;
    endtask
    // Also serves as repeated start from clock low
    task start;
        sda_o <= 1'b1;
        wq;
        scl_o <= 1'b1;
        wq;
        sda_o <= 1'b0;
        wq;
        scl_o <= 1'b0;
        wq;
    endtask
    task stop;
        sda_o <= 1'b0;
        wq;
        scl_o <= 1'b1;
        wq;
        sda_o <= 1'b1;
        wq;
    endtask
    task byte_out(input reg [7:0] b);
        integer i;
        reg     s;
        for (i = 7; i >= 0; i = i - 1)
            bit_io(b[i], s);
        bit_io(1'b1, s);
        emit({8'h00, ~s});
    endtask
    task byte_in(input reg last);
        integer   i;
        reg [7:0] d;
        reg       s;
        for (i = 7; i >= 0; i = i - 1) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        emit({1'b1, d});
        bit_io(last, s);
    endtask
    task write_block(input reg [6:0] a, input reg [7:0] idx, input reg [7:0] n,
                     input reg [63:0] d);
        integer i;
        start;
        byte_out({a, 1'b0});
        byte_out(idx);
        byte_out(n);
        for (i = 0; i < n; i = i + 1)
            byte_out(d[8*i +: 8]);
        stop;
    endtask
    task read_block(input reg [6:0] a, input reg [7:0] idx, input integer n);
        integer i;
        start;
        byte_out({a, 1'b0});
        byte_out(idx);
        start;
        byte_out({a, 1'b1});
        byte_in(1'b0);
        for (i = 1; i <= n; i = i + 1)
            byte_in(i == n);
        stop;
    endtask
endmodule

/* File: verification/clockgen_smbus_control_regs_bench.sv */
`timescale 1ns/1ps
module clockgen_smbus_control_regs_bench;
    localparam [3:0] REV = 4'h3;  // Arbitrary value
    localparam [3:0] MKR = 4'h9;  // Arbitrary value
    localparam [1:0] CAT = 2'h2;  // Arbitrary value
    localparam [5:0] DEV = 6'h2A; // Arbitrary value
    reg         clk;
    reg         reset;
    reg         pg;
    reg         addr_strap;
    reg  [1:0]  ss;
    reg  [6:0]  dev_addr;
    reg  [63:0] wd;
    reg  [31:0] rnd;
    reg  [31:0] r2;
    reg  [8:0]  exp_q[$];
    integer     n_fail, n_tests, cycles, seed;
    wire        scl, sda_host, sda_oe, res_valid, ref_run, ref_drive;
    wire [8:0]  res_data;
    wire [3:0]  pair_oe, pair_edge;
    wire [1:0]  spread, amp, ref_edge;
    wire        sda = sda_host & ~sda_oe;  // Pull-up line
    clockgen_smbus_control_regs #(.SILICON_REVISION_CODE(REV), .MAKER_CODE(MKR),
        .DEVICE_CATEGORY_CODE(CAT), .DEVICE_CODE(DEV)) clockgen_smbus_control_regs_inst (
        .clk_i(clk), .reset_i(reset), .smbus_clk_i(scl), .smbus_data_i(sda),
        .smbus_data_o(), .smbus_data_oe_o(sda_oe), .power_good_powerdown_n_i(pg),
        .bus_address_strap_i(addr_strap), .spread_strap_i(ss),
        .pair_output_enable_o(pair_oe), .pair_edge_rate_select_o(pair_edge),
        .spread_amount_o(spread), .amplitude_select_o(amp), .ref_edge_rate_o(ref_edge),
        .ref_run_o(ref_run), .ref_drive_enable_o(ref_drive));
    smbus_host_model smbus_host_model_inst (.clk_i(clk), .sda_i(sda), .scl_o(scl),
        .sda_o(sda_host), .res_valid_o(res_valid), .res_data_o(res_data));
    always #4 clk = ~clk;
    task print_verdict;
        if (n_fail == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task check_pin(input string what, input [8:0] e, input [8:0] g);
        n_tests = n_tests + 1;
        if (e !== g) begin
            n_fail = n_fail + 1;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask
    task check_bus(input [8:0] e, input [8:0] g);
        check_pin("bus result", e, g);
    endtask
    // Oldest note against each reported ack or byte
    always @(posedge clk) begin
        if (res_valid)
            check_bus(exp_q.size() > 0 ? exp_q.pop_front() : 9'hXXX, res_data);
    end
    // Hang guard, a margin above the expected run of about 106000 cycles
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 120000) begin
            n_fail = n_fail + 1;
            print_verdict;
        end
    end
    task wr(input [7:0] idx, input [7:0] n);
        repeat (3 + n) exp_q.push_back(9'h001);
        smbus_host_model_inst.write_block(dev_addr, idx, n, wd);
    endtask
    task rd(input [7:0] idx, input [7:0] cnt, input [63:0] d);
        integer i;
        repeat (3) exp_q.push_back(9'h001);
        exp_q.push_back({1'b1, cnt});
        for (i = 0; i < cnt; i = i + 1)
            exp_q.push_back({1'b1, d[8*i +: 8]});
        smbus_host_model_inst.read_block(dev_addr, idx, cnt);
    endtask
    task pins(input [3:0] oe, input [3:0] ed, input [1:0] sp, input [1:0] am,
              input [1:0] re);
        check_pin("pair enables", oe, pair_oe);
        check_pin("pair edge", ed, pair_edge);
        check_pin("spread", sp, spread);
        check_pin("amplitude", am, amp);
        check_pin("ref edge", re, ref_edge);
    endtask
    task power_dip(input run);
        pg <= 1'b0;
        repeat (12) @(posedge clk);
        check_pin("ref run", run, ref_run);
        check_pin("pairs down", 9'h000, pair_oe);
        pg <= 1'b1;
        repeat (12) @(posedge clk);
    endtask
    initial begin
        clk = 1'b0;
        reset = 1'b1;
        pg = 1'b0;
        n_fail = 0;
        n_tests = 0;
        cycles = 0;
        seed = 32'h537F2FBE;
        rnd = $random(seed);
        addr_strap = rnd[0];
        ss = (rnd[2:1] == 2'h2) ? 2'h3 : rnd[2:1];
        dev_addr = {5'h1A, addr_strap, 1'b0};
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        pins(4'h0, 4'hF, 2'h0, 2'h2, 2'h1);
        pg <= 1'b1;
        repeat (12) @(posedge clk);
        pins(4'hF, 4'hF, ss, 2'h2, 2'h1);
        check_pin("ref drive", 9'h001, ref_drive);
        // Other address: nobody answers
        exp_q.push_back(9'h000);
        smbus_host_model_inst.start;
        smbus_host_model_inst.byte_out({dev_addr ^ 7'h02, 1'b0});
        smbus_host_model_inst.stop;
        rd(8'h00, 8'h08, {8'h08, CAT, DEV, REV, MKR, 8'hFF, 8'h5F, 8'hFF, ss, 6'h06,
            8'hFF});
        power_dip(1'b0);
        // Software spread value with the select bit clear; read-only bytes hit
        rnd = $random(seed);
        r2 = $random(seed);
        wd = {r2[31:29], 5'h04, r2[23:0], rnd[31:30], 2'h3, rnd[27:16], rnd[15:14], 3'h3,
            rnd[10:0]};
        wr(8'h00, 8'h08);
        pins(rnd[3:0], rnd[19:16], ss, rnd[9:8], rnd[31:30]);
        power_dip(1'b1);
        wd = {56'h0, 5'h05, rnd[10:8]};
        wr(8'h01, 8'h01);
        pins(rnd[3:0], rnd[19:16], 2'h1, rnd[9:8], rnd[31:30]);
        rd(8'h03, 8'h04, {32'h0, CAT, DEV, REV, MKR, 8'hFF, rnd[31:30], 6'h3F});
        repeat (4) @(posedge clk);
        check_pin("notes left", 9'h000, 9'(exp_q.size()));
        print_verdict;
    end
endmodule
